// ---- dv/vfc_channel_range_pulse_output_bench.sv ----
module vfc_channel_range_pulse_output_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err, arm, done;
    logic        chan_sel_hi, chan_sel_lo, gain_sel, polarity_sel, standby_n, master_clk_in;
    logic        master_clk_copy, pulse_out, rate_valid;
    logic [11:0] paddr, ain_one, ain_two, ain_three, ain_common, span_ref_in;
    logic [31:0] pwdata, prdata, rd;
    int          count, num_errors, samples_checked, n, k, mdiv;
    // rows: {hi, lo, gain, polarity}, common input, pulses per 100 master cycles
    localparam logic [3:0]  CFG [12] = '{4'h1, 4'h5, 4'h9, 4'hD, 4'hF, 4'h7, 4'h3, 4'h3, 4'h8, 4'h4, 4'h2, 4'hC};
    localparam logic [11:0] V4 [12]  = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
                                         12'h1F4, 12'h1F4, 12'h1F4, 12'h2EE, 12'h000};
    localparam int          EXP [12] = '{25, 9, 35, 21, 37, 13, 45, 5, 30, 17, 15, 33};

    vfcpo_top #(.XTAL_START_CYC(20)) dut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .chan_sel_hi, .chan_sel_lo, .gain_sel, .polarity_sel, .standby_n, .master_clk_in,
        .ain_one, .ain_two, .ain_three, .ain_common, .span_ref_in, .master_clk_copy, .pulse_out, .rate_valid);
    vfcpo_gate_counter #(.GATE_CYC(100)) u_gate (.ref_clk, .mclk(master_clk_copy), .pulse(pulse_out), .arm,
        .count, .done);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // external master clock, eight system cycles a period
    always @(posedge ref_clk) begin
        mdiv <= (mdiv + 1) % 4;
        if (mdiv == 3) master_clk_in <= ~master_clk_in;
    end

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk

    // request held until ready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd = 32'h0000_0000);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // cycles from a change until valid; a stale valid must drop first
    task automatic settle(input int lo, input int hi);
        n = 0;
        while (rate_valid === 1'b1 && n < 9) begin
            @(posedge ref_clk);
            n++;
        end
        while (rate_valid !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n >= lo && n <= hi, "settling time");
    endtask : settle

    task automatic measure(input int exp);
        @(posedge ref_clk);
        arm <= 1'b1;
        @(posedge ref_clk);
        arm <= 1'b0;
        @(posedge ref_clk);
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            @(posedge ref_clk);
            k++;
        end
        chk(count >= exp - 1 && count <= exp + 1, "pulse count");
    endtask : measure

    task automatic clk_rate(input int exp);
        logic p;
        n = 0;
        p = master_clk_copy;
        repeat (120) begin
            @(posedge ref_clk);
            if (master_clk_copy === 1'b1 && p === 1'b0) n++;
            p = master_clk_copy;
        end
        chk(n >= exp - 1 && n <= exp + 1, "clock copy rate");
    endtask : clk_rate

    task automatic complete_run();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // watchdog: the whole sequence needs about 12000 cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        {rstn, psel, penable, pwrite, arm, master_clk_in, mdiv} = '0;
        {paddr, pwdata} = '0;
        {chan_sel_hi, chan_sel_lo, gain_sel, polarity_sel, standby_n} = 5'h01;
        {ain_one, ain_two, ain_three, ain_common, span_ref_in} = {12'h1F4, 12'h064, 12'h2EE, 12'h000, 12'h3E8};
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        apb(1'b0, 12'h000);
        chk(rd === 32'h0000_0000 && err === 1'b0, "ctrl reset value");
        apb(1'b0, 12'h00C);
        chk(err === 1'b1, "unmapped read");
        apb(1'b1, 12'h008, 32'h0000_0000);
        apb(1'b0, 12'h008);
        chk(rd === 32'h0000_1B58 && err === 1'b0, "rate word");
        clk_rate(15);
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk);
            {chan_sel_hi, chan_sel_lo, gain_sel, polarity_sel} <= CFG[i];
            ain_common <= V4[i];
            settle(10, 28);
            measure(EXP[i]);
        end
        apb(1'b1, 12'h000, 32'h0000_0002);
        settle(74, 96);
        measure(25);
        standby_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        repeat (40) begin
            @(posedge ref_clk);
            chk(pulse_out === 1'b0 && rate_valid === 1'b0, "standby output");
        end
        apb(1'b0, 12'h004);
        chk(rd[2] === 1'b1, "standby status");
        @(posedge ref_clk);
        standby_n <= 1'b1;
        settle(74, 96);
        apb(1'b1, 12'h000, 32'h0000_0001);
        settle(20, 90);
        clk_rate(20);
        measure(33);
        apb(1'b0, 12'h004);
        chk(rd[1] === 1'b1, "oscillator ready");
        complete_run();
    end
endmodule : vfc_channel_range_pulse_output_bench

// ---- dv/vfcpo_gate_counter.sv ----
module vfcpo_gate_counter #(
    parameter int GATE_CYC = 100    // gate length in master cycles
) (
    input  wire logic ref_clk,      // sampling clock
    input  wire logic mclk,         // buffered master clock copy
    input  wire logic pulse,        // frequency output
    input  wire logic arm,          // start one gated count
    output int        count,        // rising edges inside the gate
    output logic      done          // gate closed, count final
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_q  = 1'b0;
    logic pulse_q = 1'b0;
    logic gate    = 1'b0;
    int   left    = 0;

    initial begin
        count = 0;
        done = 1'b0;
    end

    // gate follows master edges, so the count is a pure clock ratio
    always @(posedge ref_clk) begin
        mclk_q <= mclk;
        pulse_q <= pulse;
        if (arm) begin
            left <= GATE_CYC;
            count <= 0;
            done <= 1'b0;
        end else if (mclk && !mclk_q) begin
            gate <= (left > 0);
            left <= (left > 0) ? left - 1 : 0;
            done <= done || (gate && left == 0);
        end
        // gate is not aligned to the pulses: one count of slack
        if (!arm && gate && pulse && !pulse_q) begin
            count <= count + 1;
        end
    end
endmodule : vfcpo_gate_counter

// ---- dv/vfcpo_top_props.sv ----
module vfcpo_top_props (
    input wire logic        ref_clk,    // system clock
    input wire logic        rstn,       // sync reset, active low
    input wire logic        psel,       // apb select
    input wire logic        penable,    // apb enable
    input wire logic [11:0] paddr,      // apb byte address
    input wire logic        pready,     // apb ready
    input wire logic        pslverr,    // apb error
    input wire logic        gain_sel,   // gain pin
    input wire logic        standby_n,  // power-down pin
    input wire logic        pulse_out,  // frequency output
    input wire logic        master_clk_copy, // copied master clock
    input wire logic        rate_valid  // settled flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // six cycles covers the pin synchroniser and the state register
    standby_quiet_a: assert property (!standby_n [*6] |-> !pulse_out && !rate_valid)
        else $error("output active in standby");
    // pulse rides the copied clock: a fixed cycle count breaks on clock switch-over
    pulse_width_a: assert property ($rose(pulse_out) |-> $rose(master_clk_copy))
        else $error("pulse not started on master edge");
    pulse_high_a: assert property (pulse_out |-> master_clk_copy)
        else $error("pulse outlived master high phase");
    pulse_gap_a: assert property ($fell(pulse_out) |-> !pulse_out [*2])
        else $error("pulse low phase too short");
    settle_gap_a: assert property ($rose(rate_valid) |-> !$past(rate_valid, 6))
        else $error("valid without settling");
    restep_a: assert property ($changed(gain_sel) && standby_n |-> ##[1:8] !rate_valid)
        else $error("select change kept valid");
    // bus answers: one wait state, one-cycle ready, error only on unmapped words
    one_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("ready not after one wait");
    ready_access_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    decode_err_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h008))
        else $error("address decode error flag wrong");

    cover property ($rose(rate_valid));
    cover property ($rose(pulse_out));
    cover property (pslverr);
endmodule : vfcpo_top_props

bind vfcpo_top vfcpo_top_props u_props (
    .ref_clk, .rstn, .psel, .penable, .paddr, .pready, .pslverr, .gain_sel, .standby_n, .pulse_out, .rate_valid,
    .master_clk_copy
);

// ---- include/vfcpo_if.sv ----
interface vfcpo_if;
    vfcpo_pkg::vfcpo_word_t num;     // rate numerator per master cycle
    vfcpo_pkg::vfcpo_word_t den;     // rate denominator
    logic                   run;     // converter active
    logic                   mrise;   // master clock rising event
    logic                   mfall;   // master clock falling event
    logic                   pulse;   // generated output pulse

    modport ctl (output num, output den, output run, output mrise, output mfall, input pulse);
    modport gen (input num, input den, input run, input mrise, input mfall, output pulse);
endinterface : vfcpo_if

// ---- include/vfcpo_params.svh ----
`ifndef VFCPO_PARAMS_SVH
`define VFCPO_PARAMS_SVH

`define VFCPO_ADDR_CTRL      12'h000
`define VFCPO_ADDR_STATUS    12'h004
`define VFCPO_ADDR_RATE      12'h008
`define VFCPO_CTRL_XTAL_BIT  0
`define VFCPO_CTRL_SINGLE_BIT 1
`define VFCPO_CTRL_RESET     2'h0
`define VFCPO_SETTLE_MULTI   4'h2
`define VFCPO_SETTLE_SINGLE  4'hA
`define VFCPO_REF_CLK_MHZ    40
`define VFCPO_XTAL_START_US  5000
`define VFCPO_XTAL_START_CYC (`VFCPO_XTAL_START_US * `VFCPO_REF_CLK_MHZ)
`define VFCPO_XTAL_HALF_CYC  3

`endif

// ---- include/vfcpo_pkg.sv ----
package vfcpo_pkg;
    // converter run state
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_SETTLE,
        ST_VALID
    } vfcpo_state_t;

    typedef logic [19:0] vfcpo_word_t;
endpackage : vfcpo_pkg

// ---- rtl/vfcpo_rate_gen.sv ----
module vfcpo_rate_gen (
    input  wire logic ref_clk,   // system clock
    input  wire logic rstn,      // sync reset, active low
    vfcpo_if.gen      bus        // rate and clock events
);
    vfcpo_pkg::vfcpo_word_t acc_r;
    vfcpo_pkg::vfcpo_word_t acc_nxt;
    logic                   pulse_r;
    logic                   pulse_nxt;
    logic [20:0]            sum;

    // phase accumulator: one overflow per output pulse
    always_comb begin
        acc_nxt   = acc_r;
        pulse_nxt = pulse_r;
        sum       = {1'b0, acc_r} + {1'b0, bus.num};
        if (!bus.run) begin
            acc_nxt   = '0;
            pulse_nxt = 1'b0;
        end else if (bus.mrise) begin
            // rate num/den of master clock, num/den within 0.05..0.45
            if (sum >= {1'b0, bus.den}) begin
                acc_nxt   = 20'(sum - {1'b0, bus.den});
                pulse_nxt = 1'b1;
            end else begin
                acc_nxt   = sum[19:0];
            end
        end else if (bus.mfall) begin
            pulse_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            acc_r   <= '0;
            pulse_r <= 1'b0;
        end else begin
            acc_r   <= acc_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign bus.pulse = pulse_r;
endmodule : vfcpo_rate_gen

// ---- rtl/vfcpo_top.sv ----
`include "vfcpo_params.svh"

module vfcpo_top #(
    parameter int XTAL_START_CYC = `VFCPO_XTAL_START_CYC   // oscillator start-up in ref_clk cycles
) (
    input  wire logic        ref_clk,          // 40 MHz system clock
    input  wire logic        rstn,             // sync reset, active low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb enable
    input  wire logic        pwrite,           // apb direction
    input  wire logic [11:0] paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    input  wire logic        chan_sel_hi,      // channel select high pin
    input  wire logic        chan_sel_lo,      // channel select low pin
    input  wire logic        gain_sel,         // front-end gain pin
    input  wire logic        polarity_sel,     // high unipolar, low bipolar
    input  wire logic        standby_n,        // power-down pin, active low
    input  wire logic        master_clk_in,    // external master clock
    input  wire logic [11:0] ain_one,          // input 1 code
    input  wire logic [11:0] ain_two,          // input 2 code
    input  wire logic [11:0] ain_three,        // input 3 code
    input  wire logic [11:0] ain_common,       // input 4 code
    input  wire logic [11:0] span_ref_in,      // reference code
    output logic             master_clk_copy,  // master clock copy
    output logic             pulse_out,        // frequency output
    output logic             rate_valid        // settled indicator
);
    localparam int NPIN = 66;

    // raw pins packed for one synchroniser loop
    logic [NPIN-1:0] raw;
    logic [NPIN-1:0] s1_r;
    logic [NPIN-1:0] s2_r;
    assign raw = {span_ref_in, ain_common, ain_three, ain_two, ain_one,
                  standby_n, master_clk_in, polarity_sel, gain_sel, chan_sel_hi, chan_sel_lo};

    // two flops per pin; analog codes are assumed quasi-static
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw[gi];
                    s2_r[gi] <= s1_r[gi];
                end
            end
        end
    endgenerate

    logic [1:0]  chan_s;
    logic        gain_s;
    logic        pol_s;
    logic        mclk_s;
    logic        stby_n_s;
    logic [11:0] a1_s;
    logic [11:0] a2_s;
    logic [11:0] a3_s;
    logic [11:0] a4_s;
    logic [11:0] ref_s;
    assign chan_s   = s2_r[1:0];
    assign gain_s   = s2_r[2];
    assign pol_s    = s2_r[3];
    assign mclk_s   = s2_r[4];
    assign stby_n_s = s2_r[5];
    assign a1_s     = s2_r[17:6];
    assign a2_s     = s2_r[29:18];
    assign a3_s     = s2_r[41:30];
    assign a4_s     = s2_r[53:42];
    assign ref_s    = s2_r[65:54];

    // signed difference of the routed pair
    function automatic logic signed [12:0] vfcpo_pair_diff(
        input logic [1:0]  sel,
        input logic        single,
        input logic [11:0] v1,
        input logic [11:0] v2,
        input logic [11:0] v3,
        input logic [11:0] v4
    );
        logic [11:0] vp;
        logic [11:0] vm;
        vp = v1;
        vm = v4;
        if (single) begin
            vm = 12'h000;
        end else begin
            case (sel)
                2'b00:   begin vp = v1; vm = v4; end
                2'b01:   begin vp = v2; vm = v4; end
                2'b10:   begin vp = v3; vm = v4; end
                2'b11:   begin vp = v1; vm = v2; end
                default: begin vp = v1; vm = v4; end
            endcase
        end
        return $signed({1'b0, vp}) - $signed({1'b0, vm});
    endfunction : vfcpo_pair_diff

    // control register and apb slave
    logic [1:0]  ctrl_r;
    logic [1:0]  ctrl_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        xtal_sel;
    logic        single;
    assign xtal_sel = ctrl_r[`VFCPO_CTRL_XTAL_BIT];
    assign single   = ctrl_r[`VFCPO_CTRL_SINGLE_BIT];

    vfcpo_pkg::vfcpo_state_t state_r;
    vfcpo_pkg::vfcpo_state_t state_nxt;
    vfcpo_pkg::vfcpo_word_t  num_r;
    vfcpo_pkg::vfcpo_word_t  num_nxt;
    vfcpo_pkg::vfcpo_word_t  den_r;
    vfcpo_pkg::vfcpo_word_t  den_nxt;
    logic                    osc_ready_r;
    logic                    mapped;

    // ready one cycle into access; writes land at the ready edge
    always_comb begin
        ctrl_nxt    = ctrl_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        mapped      = (paddr == `VFCPO_ADDR_CTRL) || (paddr == `VFCPO_ADDR_STATUS) ||
                      (paddr == `VFCPO_ADDR_RATE);
        if (psel && penable && !pready_r) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = !mapped;
            prdata_nxt  = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `VFCPO_ADDR_CTRL:   prdata_nxt = {30'h0000_0000, ctrl_r};
                    `VFCPO_ADDR_STATUS: prdata_nxt = {24'h00_0000, gain_s, pol_s, chan_s,
                                                      pulse_out, !stby_n_s, osc_ready_r,
                                                      state_r == vfcpo_pkg::ST_VALID};
                    `VFCPO_ADDR_RATE:   prdata_nxt = {12'h000, num_r};
                    default:            prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
        if (psel && penable && pready_r && pwrite && paddr == `VFCPO_ADDR_CTRL) begin
            ctrl_nxt = pwdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_r    <= `VFCPO_CTRL_RESET;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // crystal oscillator model: divider plus start-up wait
    logic [17:0] start_cnt_r;
    logic [17:0] start_cnt_nxt;
    logic [3:0]  div_r;
    logic [3:0]  div_nxt;
    logic        osc_r;
    logic        osc_nxt;
    logic        osc_ready_nxt;
    always_comb begin
        start_cnt_nxt = start_cnt_r;
        div_nxt       = div_r;
        osc_nxt       = osc_r;
        osc_ready_nxt = osc_ready_r;
        if (!xtal_sel || !stby_n_s) begin
            start_cnt_nxt = 18'h0_0000;
            div_nxt       = 4'h0;
            osc_nxt       = 1'b0;
            osc_ready_nxt = 1'b0;
        end else begin
            if (div_r == 4'(`VFCPO_XTAL_HALF_CYC - 1)) begin
                div_nxt = 4'h0;
                osc_nxt = !osc_r;
            end else begin
                div_nxt = div_r + 4'h1;
            end
            // no usable clock edges until start-up ends
            if (start_cnt_r == 18'(XTAL_START_CYC - 1)) begin
                osc_ready_nxt = 1'b1;
            end else begin
                start_cnt_nxt = start_cnt_r + 18'h0_0001;
            end
        end
    end

    // selected master clock, edge events and clock copy
    logic mclk_sel;
    logic mclk_d_r;
    logic mclk_copy_r;
    assign mclk_sel = xtal_sel ? (osc_r && osc_ready_r) : mclk_s;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            start_cnt_r <= 18'h0_0000;
            div_r       <= 4'h0;
            osc_r       <= 1'b0;
            osc_ready_r <= 1'b0;
            mclk_d_r    <= 1'b0;
            mclk_copy_r <= 1'b0;
        end else begin
            start_cnt_r <= start_cnt_nxt;
            div_r       <= div_nxt;
            osc_r       <= osc_nxt;
            osc_ready_r <= osc_ready_nxt;
            mclk_d_r    <= mclk_sel;
            mclk_copy_r <= mclk_sel;
        end
    end

    // rate numerator and denominator from pair, gain and polarity
    logic signed [12:0] diff;
    logic signed [19:0] gd;
    logic signed [19:0] ref20;
    logic signed [19:0] n;
    always_comb begin
        diff  = vfcpo_pair_diff(chan_s, single, a1_s, a2_s, a3_s, a4_s);
        ref20 = $signed({8'h00, (ref_s == 12'h000) ? 12'h001 : ref_s});
        gd    = {{7{diff[12]}}, diff};
        if (gain_s && !single) begin
            gd = gd <<< 1;
        end
        if (pol_s || single) begin
            n = ref20 + (gd <<< 3);
        end else begin
            n = (ref20 <<< 2) + ref20 + (gd <<< 2);
        end
        // clamp to both ends of the range: 0.05 and 0.45 of 20*ref
        if (n < ref20) begin
            n = ref20;
        end else if (n > (ref20 <<< 3) + ref20) begin
            n = (ref20 <<< 3) + ref20;
        end
        num_nxt = n;
        den_nxt = (ref20 <<< 4) + (ref20 <<< 2);
    end

    // settling state machine
    logic [3:0] settle_cnt_r;
    logic [3:0] settle_cnt_nxt;
    logic [5:0] cfg_r;
    logic [5:0] cfg;
    logic       step;
    logic       rise;
    logic       fall;
    assign cfg  = {single, xtal_sel, gain_s, pol_s, chan_s};
    assign rise = mclk_sel && !mclk_d_r;
    assign fall = !mclk_sel && mclk_d_r;
    assign step = (cfg != cfg_r) || (num_nxt != num_r);

    always_comb begin
        state_nxt      = state_r;
        settle_cnt_nxt = settle_cnt_r;
        case (state_r)
            vfcpo_pkg::ST_STANDBY: begin
                settle_cnt_nxt = 4'h0;
                if (stby_n_s) begin
                    state_nxt = vfcpo_pkg::ST_SETTLE;
                end
            end
            vfcpo_pkg::ST_SETTLE: begin
                if (rise) begin
                    settle_cnt_nxt = settle_cnt_r + 4'h1;
                    if (settle_cnt_r + 4'h1 >= (single ? `VFCPO_SETTLE_SINGLE : `VFCPO_SETTLE_MULTI)) begin
                        state_nxt = vfcpo_pkg::ST_VALID;
                    end
                end
            end
            vfcpo_pkg::ST_VALID: begin
                settle_cnt_nxt = 4'h0;
            end
            default: begin
                state_nxt      = vfcpo_pkg::ST_STANDBY;
                settle_cnt_nxt = 4'h0;
            end
        endcase
        if (step && state_r != vfcpo_pkg::ST_STANDBY) begin
            state_nxt      = vfcpo_pkg::ST_SETTLE;
            settle_cnt_nxt = 4'h0;
        end
        if (!stby_n_s) begin
            state_nxt      = vfcpo_pkg::ST_STANDBY;
            settle_cnt_nxt = 4'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r      <= vfcpo_pkg::ST_STANDBY;
            settle_cnt_r <= 4'h0;
            cfg_r        <= 6'h00;
            num_r        <= 20'h0_0000;
            den_r        <= 20'h0_0014;
            rate_valid   <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            settle_cnt_r <= settle_cnt_nxt;
            cfg_r        <= cfg;
            num_r        <= num_nxt;
            den_r        <= den_nxt;
            rate_valid   <= (state_nxt == vfcpo_pkg::ST_VALID);
        end
    end

    vfcpo_if u_link ();
    assign u_link.num   = num_r;
    assign u_link.den   = den_r;
    assign u_link.run   = (state_r != vfcpo_pkg::ST_STANDBY);
    assign u_link.mrise = rise;
    assign u_link.mfall = fall;

    vfcpo_rate_gen u_gen (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .bus     (u_link.gen)
    );

    // outputs from flops
    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign master_clk_copy = mclk_copy_r;
    assign pulse_out       = u_link.pulse;
endmodule : vfcpo_top
